// ==== shared/dws_consts.svh ====
`ifndef DWS_CONSTS_SVH
`define DWS_CONSTS_SVH

// ==========================================================
// Slave address
`define DWS_ADDR_FIXED   5'h0b
`define DWS_ADDR_HI_POS  2
`define DWS_ADDR_LO_POS  1
`define DWS_RW_POS       0

// ==========================================================
// Instruction byte field positions
`define DWS_INS_SEL      7
`define DWS_INS_MID      6
`define DWS_INS_PD       5
`define DWS_INS_LO1      4
`define DWS_INS_LO2      3

// ==========================================================
// Reset values and counts
`define DWS_MIDSCALE     8'h80
`define DWS_LAST_BIT     3'h7
`define DWS_LOGIC_RST    1'b0

`endif

// ==== shared/dws_pkg.sv ====
`default_nettype none
package dws_pkg;

	// ==========================================================
	// Link sequencer states, one-hot
	typedef enum logic [8:0]
	{
		DWS_IDLE      = 9'h001,
		DWS_ADDR      = 9'h002,
		DWS_ACK_ADDR  = 9'h004,
		DWS_INSTR     = 9'h008,
		DWS_ACK_INSTR = 9'h010,
		DWS_DATA      = 9'h020,
		DWS_ACK_DATA  = 9'h040,
		DWS_TX        = 9'h080,
		DWS_ACK_TX    = 9'h100
	} dws_state_e;

	// Two 8-bit wiper codes, channel one at index 0
	typedef logic [1:0][7:0] dws_codes_t;

	// Word handed from the link domain to the system domain
	typedef struct packed
	{
		logic       is_data;
		logic [7:0] instr;
		logic [7:0] data;
	} dws_cmd_s;

endpackage
`default_nettype wire

// ==== rtl/dws_wiper_i2c.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dws_consts.svh"

module dws_wiper_i2c
(
	// System clock and reset
	input  wire logic               clock,
	input  wire logic               sys_rst,
	// Serial link, SCL is the link clock
	input  wire logic               scl_clk,
	input  wire logic               sda_in,
	output logic                    sda_o,
	output logic                    sda_oe_n,
	// Address straps
	input  wire logic               addr_select_pin_lo,
	input  wire logic               addr_select_pin_hi,
	// Asynchronous shutdown pin
	input  wire logic               power_down_n_pin,
	// Wiper and logic outputs
	output dws_pkg::dws_codes_t     wiper_pos,
	output logic [1:0]              chan_parked,
	output logic                    logic_out_first,
	output logic                    logic_out_second
);

	// ==========================================================
	// Start detection on the falling SDA edge
	logic start_tog_q;
	logic start_tog_d;

	// Start is SDA falling while SCL is high
	always_comb
	begin
		start_tog_d = scl_clk ? ~start_tog_q : start_tog_q;
	end

	always_ff @(negedge sda_in or posedge sys_rst)
	begin
		if (sys_rst)
			start_tog_q <= 1'b0;
		else
			start_tog_q <= start_tog_d;
	end

	// ==========================================================
	// SDA sampled on the rising SCL edge
	logic sda_rise_q;

	always_ff @(posedge scl_clk or posedge sys_rst)
	begin
		if (sys_rst)
			sda_rise_q <= 1'b1;
		else
			sda_rise_q <= sda_in;
	end

	// ==========================================================
	// Link sequencer on the falling SCL edge
	dws_pkg::dws_state_e st_q,         st_d;
	logic [2:0]          cnt_q,        cnt_d;
	logic [7:0]          shf_q,        shf_d;
	logic [7:0]          txsh_q,       txsh_d;
	logic [7:0]          instr_q,      instr_d;
	logic                rw_q,         rw_d;
	logic                sel_q,        sel_d;
	dws_pkg::dws_codes_t shadow_q,     shadow_d;
	dws_pkg::dws_cmd_s   cmd_q,        cmd_d;
	logic                cmd_tog_q,    cmd_tog_d;
	logic                seen_q,       seen_d;
	logic                oe_n_q,       oe_n_d;
	logic [1:0]          strap_s1_q;
	logic [1:0]          strap_s2_q;
	logic                start_det;
	logic [7:0]          rx_byte;

	// Straps pass two flops before the address compare reads them
	always_ff @(negedge scl_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			strap_s1_q <= 2'h0;
			strap_s2_q <= 2'h0;
		end
		else
		begin
			strap_s1_q <= {addr_select_pin_hi, addr_select_pin_lo};
			strap_s2_q <= strap_s1_q;
		end
	end

	// Toggle is stable through SCL low, so the falling edge may read it
	assign start_det = start_tog_q ^ seen_q;
	assign rx_byte   = {shf_q[6:0], sda_rise_q};

	// Next state of the sequencer
	always_comb
	begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		shf_d     = shf_q;
		txsh_d    = txsh_q;
		instr_d   = instr_q;
		rw_d      = rw_q;
		sel_d     = sel_q;
		shadow_d  = shadow_q;
		cmd_d     = cmd_q;
		cmd_tog_d = cmd_tog_q;
		seen_d    = start_tog_q;
		oe_n_d    = 1'b1;
		if (start_det)
		begin
			st_d  = dws_pkg::DWS_ADDR;
			cnt_d = 3'h0;
		end
		else
		begin
			case (st_q)
				dws_pkg::DWS_IDLE:
				begin
					cnt_d = 3'h0;
				end
				dws_pkg::DWS_ADDR:
				begin
					shf_d = rx_byte;
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == `DWS_LAST_BIT)
					begin
						if (rx_byte[7:3] == `DWS_ADDR_FIXED
							&& rx_byte[`DWS_ADDR_HI_POS] == strap_s2_q[1]
							&& rx_byte[`DWS_ADDR_LO_POS] == strap_s2_q[0])
						begin
							oe_n_d = 1'b0;
							rw_d   = rx_byte[`DWS_RW_POS];
							st_d   = dws_pkg::DWS_ACK_ADDR;
						end
						else
							st_d = dws_pkg::DWS_IDLE;
					end
				end
				dws_pkg::DWS_ACK_ADDR:
				begin
					cnt_d = 3'h0;
					if (rw_q)
					begin
						// Read of the channel chosen by the last write
						oe_n_d = shadow_q[sel_q][7];
						txsh_d = {shadow_q[sel_q][6:0], 1'b0};
						st_d   = dws_pkg::DWS_TX;
					end
					else
						st_d = dws_pkg::DWS_INSTR;
				end
				dws_pkg::DWS_INSTR:
				begin
					shf_d = rx_byte;
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == `DWS_LAST_BIT)
					begin
						instr_d = rx_byte;
						sel_d   = rx_byte[`DWS_INS_SEL];
						if (rx_byte[`DWS_INS_MID])
							shadow_d[rx_byte[`DWS_INS_SEL]] = `DWS_MIDSCALE;
						cmd_d     = '{is_data: 1'b0, instr: rx_byte, data: 8'h00};
						cmd_tog_d = ~cmd_tog_q;
						oe_n_d    = 1'b0;
						st_d      = dws_pkg::DWS_ACK_INSTR;
					end
				end
				dws_pkg::DWS_ACK_INSTR:
				begin
					cnt_d = 3'h0;
					st_d  = dws_pkg::DWS_DATA;
				end
				dws_pkg::DWS_DATA:
				begin
					shf_d = rx_byte;
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == `DWS_LAST_BIT)
					begin
						shadow_d[sel_q] = rx_byte;
						cmd_d     = '{is_data: 1'b1, instr: instr_q, data: rx_byte};
						cmd_tog_d = ~cmd_tog_q;
						oe_n_d    = 1'b0;
						st_d      = dws_pkg::DWS_ACK_DATA;
					end
				end
				dws_pkg::DWS_ACK_DATA:
				begin
					// Extra bytes are not acknowledged
					st_d = dws_pkg::DWS_IDLE;
				end
				dws_pkg::DWS_TX:
				begin
					if (cnt_q == `DWS_LAST_BIT)
						st_d = dws_pkg::DWS_ACK_TX;
					else
					begin
						oe_n_d = txsh_q[7];
						txsh_d = {txsh_q[6:0], 1'b0};
						cnt_d  = cnt_q + 3'h1;
					end
				end
				dws_pkg::DWS_ACK_TX:
				begin
					cnt_d = 3'h0;
					// Master acknowledge repeats the same code
					if (!sda_rise_q)
					begin
						oe_n_d = shadow_q[sel_q][7];
						txsh_d = {shadow_q[sel_q][6:0], 1'b0};
						st_d   = dws_pkg::DWS_TX;
					end
					else
						st_d = dws_pkg::DWS_IDLE;
				end
				default:
				begin
					st_d = dws_pkg::DWS_IDLE;
				end
			endcase
		end
	end

	// Link registers; SDA changes only while SCL is low
	always_ff @(negedge scl_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q      <= dws_pkg::DWS_IDLE;
			cnt_q     <= 3'h0;
			shf_q     <= 8'h00;
			txsh_q    <= 8'h00;
			instr_q   <= 8'h00;
			rw_q      <= 1'b0;
			sel_q     <= 1'b0;
			shadow_q  <= {`DWS_MIDSCALE, `DWS_MIDSCALE};
			cmd_q     <= '0;
			cmd_tog_q <= 1'b0;
			seen_q    <= 1'b0;
			oe_n_q    <= 1'b1;
		end
		else
		begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			shf_q     <= shf_d;
			txsh_q    <= txsh_d;
			instr_q   <= instr_d;
			rw_q      <= rw_d;
			sel_q     <= sel_d;
			shadow_q  <= shadow_d;
			cmd_q     <= cmd_d;
			cmd_tog_q <= cmd_tog_d;
			seen_q    <= seen_d;
			oe_n_q    <= oe_n_d;
		end
	end

	// Open drain: only ever pulls low
	assign sda_o    = 1'b0;
	assign sda_oe_n = oe_n_q;

	// ==========================================================
	// System domain: command capture and channel state
	logic                tog_s1_q, tog_s2_q, tog_s3_q;
	logic                pin_s1_q, pin_s2_q;
	logic                cmd_evt;
	dws_pkg::dws_codes_t wiper_q,  wiper_d;
	logic [1:0]          pd_q,     pd_d;
	logic                lo1_q,    lo1_d;
	logic                lo2_q,    lo2_d;
	logic [1:0]          park_q,   park_d;

	// Toggle and pin pass two flops; third flop finds the edge
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_s3_q <= 1'b0;
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end
		else
		begin
			tog_s1_q <= cmd_tog_q;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
			pin_s1_q <= power_down_n_pin;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Command word is held stable for the whole next byte
	assign cmd_evt = tog_s2_q ^ tog_s3_q;

	// Next channel state
	always_comb
	begin
		wiper_d = wiper_q;
		pd_d    = pd_q;
		lo1_d   = lo1_q;
		lo2_d   = lo2_q;
		if (cmd_evt)
		begin
			if (cmd_q.is_data)
				wiper_d[cmd_q.instr[`DWS_INS_SEL]] = cmd_q.data;
			else
			begin
				if (cmd_q.instr[`DWS_INS_MID])
					wiper_d[cmd_q.instr[`DWS_INS_SEL]] = `DWS_MIDSCALE;
				pd_d[cmd_q.instr[`DWS_INS_SEL]] = cmd_q.instr[`DWS_INS_PD];
				lo1_d = cmd_q.instr[`DWS_INS_LO1];
				lo2_d = cmd_q.instr[`DWS_INS_LO2];
			end
		end
		// Bit parks the selected channel, pin parks both; opposite polarity
		park_d = pd_d | {2{~pin_s2_q}};
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wiper_q <= {`DWS_MIDSCALE, `DWS_MIDSCALE};
			pd_q    <= 2'h0;
			lo1_q   <= `DWS_LOGIC_RST;
			lo2_q   <= `DWS_LOGIC_RST;
		end
		else
		begin
			wiper_q <= wiper_d;
			pd_q    <= pd_d;
			lo1_q   <= lo1_d;
			lo2_q   <= lo2_d;
		end
	end

	// Pin parks at once, no clock needed; codes untouched
	always_ff @(posedge clock or posedge sys_rst or negedge power_down_n_pin)
	begin
		if (!power_down_n_pin)
			park_q <= 2'h3;
		else if (sys_rst)
			park_q <= 2'h0;
		else
			park_q <= park_d;
	end

	// Held code is always the applied code once unparked
	assign wiper_pos        = wiper_q;
	assign chan_parked      = park_q;
	assign logic_out_first  = lo1_q;
	assign logic_out_second = lo2_q;

endmodule
`default_nettype wire

// ==== test/dws_i2c_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module dws_i2c_master
(
	// Link wires, open drain, high means released
	output logic      scl,
	output logic      sda_m,
	input  wire logic line
);
	// ==========
	// Bus idle: both wires released, clock stands still
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	// Data falls while the clock is high
	task automatic start();
		sda_m = 1'b0;
		#3 scl = 1'b0;
		#1.5;
	endtask

	// Data rises while the clock is high, then the clock parks
	task automatic stop();
		sda_m = 1'b0;
		#1.5 scl = 1'b1;
		#1.5 sda_m = 1'b1;
		#3;
	endtask

	// One bit; data only moves while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_m = b;
		#1.5 scl = 1'b1;
		#3 r = line;
		scl = 1'b0;
		#1.5;
	endtask

	// Eight bits MSB first, then the ninth bit as m
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(m, r);
		ack = ~r;
	endtask
endmodule
`default_nettype wire

// ==== test/dws_wiper_i2c_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dws_consts.svh"
module dws_wiper_i2c_props
(
	// Clocks and reset
	input wire logic                clock,
	input wire logic                sys_rst,
	input wire logic                scl_clk,
	// Link and pin
	input wire logic                sda_o,
	input wire logic                sda_oe_n,
	input wire logic                power_down_n_pin,
	// Outputs
	input wire dws_pkg::dws_codes_t wiper_pos,
	input wire logic [1:0]          chan_parked,
	input wire logic                logic_out_first,
	input wire logic                logic_out_second
);
	// ==========
	// Link idle counter
	logic [3:0] idle_q;
	logic [3:0] idle_d;
	logic       scl_q;

	// Saturates, so a long idle never wraps back to busy
	always_comb
	begin
		idle_d = (scl_clk != scl_q) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hf};
	end

	// Registers only
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			idle_q <= 4'h0;
			scl_q  <= 1'b1;
		end
		else
		begin
			idle_q <= idle_d;
			scl_q  <= scl_clk;
		end
	end

	// ==========
	// SDA enable as seen at the rising link clock
	logic oe_rise_q;

	// A move while the clock is high would read as a start or stop
	always_ff @(posedge scl_clk or posedge sys_rst)
	begin
		if (sys_rst)
			oe_rise_q <= 1'b1;
		else
			oe_rise_q <= sda_oe_n;
	end

	// ==========
	// Assertions
	drive_low_a: assert property (@(negedge scl_clk) disable iff (sys_rst)
		sda_o == 1'b0 && sda_oe_n == oe_rise_q)
		else $error("data line moved while clock high");
	reset_values_a: assert property (@(posedge clock) sys_rst |-> sda_oe_n
		&& wiper_pos == {2{`DWS_MIDSCALE}} && !logic_out_first && !logic_out_second)
		else $error("reset values wrong");
	pin_parks_a: assert property (@(posedge clock) disable iff (sys_rst)
		!power_down_n_pin |-> chan_parked == 2'h3)
		else $error("pin did not park both");
	idle_codes_a: assert property (@(posedge clock) disable iff (sys_rst)
		idle_q > 4'h8 |-> $stable(wiper_pos))
		else $error("code moved on idle link");
	idle_outs_a: assert property (@(posedge clock) disable iff (sys_rst)
		idle_q > 4'h8 |-> $stable({logic_out_first, logic_out_second}))
		else $error("logic outs moved on idle link");
	idle_parks_a: assert property (@(posedge clock) disable iff (sys_rst)
		idle_q > 4'h8 && power_down_n_pin && $past(power_down_n_pin, 4) |-> $stable(chan_parked))
		else $error("park moved on idle link");
	idle_release_a: assert property (@(posedge clock) disable iff (sys_rst)
		idle_q > 4'h8 |-> sda_oe_n)
		else $error("data line held on idle link");
	one_channel_a: assert property (@(posedge clock) disable iff (sys_rst)
		$changed(wiper_pos[0]) |-> $stable(wiper_pos[1]))
		else $error("both channels changed");
endmodule

bind dws_wiper_i2c dws_wiper_i2c_props dws_wiper_i2c_props_i
(
	.clock, .sys_rst, .scl_clk, .sda_o, .sda_oe_n, .power_down_n_pin,
	.wiper_pos, .chan_parked, .logic_out_first, .logic_out_second
);
`default_nettype wire

// ==== test/dws_wiper_i2c_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module dws_wiper_i2c_tb;
	// Design pins and bench state
	logic                clock, sys_rst, scl_clk, sda_m, power_down_n_pin;
	logic                addr_select_pin_lo, addr_select_pin_hi;
	logic                sda_o, sda_oe_n, logic_out_first, logic_out_second;
	wire logic           sda_in;
	dws_pkg::dws_codes_t wiper_pos;
	logic [1:0]          chan_parked;
	logic [31:0]         obs;
	int                  errors;
	int                  n_compared;

	// Pulled-up wired AND of both drivers
	assign sda_in = sda_m & (sda_oe_n | sda_o);
	assign obs = {wiper_pos, logic_out_first, logic_out_second, chan_parked, 12'h000};

	dws_wiper_i2c dws_wiper_i2c_i
	(
		.clock, .sys_rst, .scl_clk, .sda_in, .sda_o, .sda_oe_n,
		.addr_select_pin_lo, .addr_select_pin_hi, .power_down_n_pin,
		.wiper_pos, .chan_parked, .logic_out_first, .logic_out_second
	);
	dws_i2c_master dws_i2c_master_i (.scl(scl_clk), .sda_m, .line(sda_in));

	// ==========
	// 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic finish_test();
		if (errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One frame: address, then n write bytes or n read bytes
	task automatic xact(input logic [7:0] a, ins, d, input int n, output logic [7:0] q);
		logic k;
		logic e;
		e = a[7:1] == {5'h0b, addr_select_pin_hi, addr_select_pin_lo};
		dws_i2c_master_i.start();
		dws_i2c_master_i.xfer(a, 1'b1, q, k);
		chk("addr ack", 32'(k), 32'(e));
		for (int i = 0; i < n; i++)
		begin
			if (a[0])
			begin
				// Master acks all but the last byte, so repeats are exercised
				dws_i2c_master_i.xfer(8'hff, i == n - 1, q, k);
			end
			else
			begin
				dws_i2c_master_i.xfer(i ? d : ins, 1'b1, q, k);
				chk("byte ack", 32'(k), 32'(1'b1));
			end
		end
		dws_i2c_master_i.stop();
		repeat (10) @(negedge clock);
	endtask

	// ==========
	// Main sequence
	initial
	begin
		logic [7:0] q;
		{sys_rst, addr_select_pin_hi, addr_select_pin_lo, power_down_n_pin} = 4'h9;
		repeat (3) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		chk("reset", obs, 32'h8080_0000);
		repeat (2) @(negedge clock);
		for (int k = 0; k < 4; k++)
		begin
			{addr_select_pin_hi, addr_select_pin_lo} = 2'(k);
			xact({5'h0b, 2'(k), 1'b0}, 8'h00, 8'h00, 0, q);
			xact({5'h0b, 2'(~k), 1'b0}, 8'h00, 8'h00, 0, q);
			xact({5'h1b, 2'(k), 1'b0}, 8'h00, 8'h00, 0, q);
		end
		xact(8'h5e, 8'h17, 8'h3c, 2, q);
		chk("ch1 write", obs, 32'h803c_8000);
		xact(8'h5e, 8'h88, 8'ha5, 2, q);
		chk("ch2 write", obs, 32'ha53c_4000);
		xact(8'h5f, 8'h00, 8'h00, 2, q);
		chk("read ch2", 32'(q), 32'h0000_00a5);
		xact(8'h5e, 8'h40, 8'h00, 1, q);
		chk("ch1 mid", obs, 32'ha580_0000);
		xact(8'h5f, 8'h00, 8'h00, 1, q);
		chk("read ch1", 32'(q), 32'h0000_0080);
		xact(8'h5e, 8'ha0, 8'h11, 2, q);
		chk("ch2 down", obs, 32'h1180_2000);
		power_down_n_pin = 1'b0;
		#1;
		chk("pin down", obs, 32'h1180_3000);
		xact(8'h5e, 8'h00, 8'h66, 2, q);
		chk("parked write", obs, 32'h1166_3000);
		power_down_n_pin = 1'b1;
		repeat (5) @(negedge clock);
		chk("pin up", obs, 32'h1166_2000);
		xact(8'h5e, 8'h80, 8'h00, 1, q);
		chk("ch2 up", obs, 32'h1166_0000);
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		chk("second reset", obs, 32'h8080_0000);
		repeat (2) @(negedge clock);
		xact(8'h5f, 8'h00, 8'h00, 1, q);
		chk("read after reset", 32'(q), 32'h0000_0080);
		finish_test();
	end

	// Watchdog: the sequence needs well under 20 us
	initial
	begin
		#100000;
		errors++;
		finish_test();
	end
endmodule
`default_nettype wire
